// ---- spmc_clk_gen.sv ----
// Glitch-free system clock tick generator that divides and selects the oscillator ticks.
`timescale 1ns/1ns

module spmc_clk_gen (
  input wire logic mclk,
  input wire logic reset,
  input wire logic lsTick,
  input wire logic hsTick,
  input wire logic [1:0] srcSel,
  input wire logic [2:0] divShift,
  output logic sysTick
);

  // Whole state of the generator.
  typedef struct packed {
    logic [1:0] sel;
    logic [2:0] shift;
    logic [5:0] cnt;
    logic tick;
  } spmc_gen_t;

  spmc_gen_t s_r;
  spmc_gen_t s_nxt;
  logic srcTick;
  logic [5:0] limit;

  // A new source or ratio is adopted only when the current period has ended or the clock is stopped, so no phase is cut short.
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    limit = 6'((7'h01 << s_r.shift) - 7'h01);
    srcTick = (s_r.sel == spmc_pkg::SRC_LS) ? lsTick : ((s_r.sel == spmc_pkg::SRC_HS) ? hsTick : 1'b0);
    if (s_r.sel == spmc_pkg::SRC_OFF) begin
      // A stopped clock has no phase in flight and may restart on any source at once.
      s_nxt.sel = srcSel; // R17
      s_nxt.shift = divShift;
      s_nxt.cnt = 6'h00;
    end else if (srcTick) begin
      if (s_r.cnt == limit) begin
        s_nxt.tick = 1'b1;
        s_nxt.cnt = 6'h00;
        s_nxt.sel = srcSel; // R17
        s_nxt.shift = divShift;
      end else begin
        s_nxt.cnt = s_r.cnt + 6'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sysTick = s_r.tick;

endmodule

// ---- spmc_pkg.sv ----
// Package holding register map, field layout, reset values, counts and state codes of the power mode controller.
package spmc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_IDLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ENABLES = 8'h0C;

  // Field positions of power_mode_clock_select.
  localparam int MODE_DIV_HI = 7;
  localparam int MODE_DIV_LO = 5;
  localparam int MODE_FAST = 4;
  localparam int MODE_LSRDY = 3;
  localparam int MODE_HSRDY = 2;
  localparam int MODE_IDLE = 1;
  localparam int MODE_HIGH_CLOCK_SELECT = 0;

  // Field positions of idle_clock_and_reset_flags.
  localparam int IDLE_KEEP = 7;
  localparam int IDLE_FLAGS_HI = 2;
  localparam int IDLE_FLAGS_LO = 0;

  // Field positions of the status and enables registers.
  localparam int STAT_PDF = 0;
  localparam int STAT_TO = 1;
  localparam int EN_LVD = 0;
  localparam int EN_LCD = 1;

  // Reset values of the writable fields.
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic RST_FAST = 1'b0;
  localparam logic RST_IDLE = 1'b1;
  localparam logic RST_HIGH_CLOCK_SELECT = 1'b1;
  localparam logic RST_KEEP = 1'b0;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  // Divider codes at or above this value pick the high-speed clock.
  localparam logic [2:0] DIV_FIRST_HS = 3'h2;
  // The divide shift is this value minus the divider code.
  localparam logic [3:0] DIV_SHIFT_BASE = 4'h8;

  // Oscillator cycles until ready; the upper end of each printed range is used.
  localparam logic [10:0] CNT_XTAL = 11'h400;
  localparam logic [10:0] CNT_LS_RC = 11'h002;
  localparam logic [10:0] CNT_HS_RC = 11'h010;
  // Low-speed cycles before the CPU resumes in fast wake-up.
  localparam logic [1:0] CNT_FAST = 2'h2;

  // System clock source selection.
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_LS = 2'h1;
  localparam logic [1:0] SRC_HS = 2'h2;

  // Operating states, one-hot.
  typedef enum logic [5:0] {
    ST_RUN = 6'b00_0001,
    ST_DEEP = 6'b00_0010,
    ST_LIGHT = 6'b00_0100,
    ST_IDLE_STOP = 6'b00_1000,
    ST_IDLE_RUN = 6'b01_0000,
    ST_WAKE = 6'b10_0000
  } spmc_state_t;

  // Divide shift for a divider field and high clock select; zero means undivided.
  function automatic logic [2:0] div_shift(input logic high_clock_select, input logic [2:0] div);
    logic [3:0] s;
    s = DIV_SHIFT_BASE - {1'b0, div};
    // The two low-speed codes run the low clock undivided, so they must not inherit a shift.
    return (high_clock_select || div < DIV_FIRST_HS) ? 3'h0 : s[2:0];
  endfunction

endpackage

// ---- spmc_sysclk_power_mode_ctrl.sv ----
// Top of the system clock selection and low-power mode controller with its APB register file.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns

// Function
// R1: Halt, idle off, no users: deep sleep.
// R2: Voltage detector or display enable block deep sleep.
// R3: Light sleep keeps low-speed and watchdog clocks.
// R4: Halt with idle, no keep: idle stopped.
// R5: Idle stopped watchdog clock follows its source.
// R6: Halt with idle and keep: idle running.
// R7: Divider field picks low-speed or divided high-speed.
// R8: High select undivided; low-speed turns high oscillator off.
// R9: Low ready low in deep, counts after wake.
// R10: High ready counts 1024 or 16 after wake.
// R11: Fast wake bit 4, crystal only.
// R12: Fast wake only from light or idle stopped.
// R13: Fast wake resumes on low clock, switches later.
// R14: RC oscillators wake by count, fast bit ignored.
// R15: Idle keep is bit 7; bits 6-3 zero.
// R16: Any sleep entry sets power-down, clears timeout.
// R17: Clock source switching is glitch-free.
module spmc_sysclk_power_mode_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic haltReq,
  input wire logic wakeReq,
  input wire logic lsTick,
  input wire logic hsTick,
  input wire logic lsIsCrystal,
  input wire logic hsIsCrystal,
  input wire logic wdtEnable,
  input wire logic wdtSrcLow,
  input wire logic wdtTimeout,
  output logic sysTick,
  output logic cpuRun,
  output logic lsClkOn,
  output logic wdtClkOn,
  output logic hsOscOn,
  output logic wdtClear,
  output logic fastWakeActive,
  output logic [5:0] powerState
);

  // Whole state of the controller.
  typedef struct packed {
    spmc_pkg::spmc_state_t st; // Operating state.
    logic [2:0] divSel; // Divider field.
    logic fastEn; // Fast wake enable.
    logic idleEn; // Idle enable.
    logic high_clock_select; // High clock select.
    logic keepClk; // Idle clock keep.
    logic [2:0] rstFlags; // Reset cause flags, plain storage here.
    logic voltage_detector_enable; // Voltage detector enable.
    logic lcdEn; // Display driver enable.
    logic power_down_flag; // Power-down flag.
    logic wdtTo; // Watchdog time-out flag.
    logic lsRdy; // Low-speed ready flag.
    logic hsRdy; // High-speed ready flag.
    logic [10:0] lsCnt; // Low-speed stabilisation count.
    logic [10:0] hsCnt; // High-speed stabilisation count.
    logic [1:0] wakeCnt; // Low-speed cycles counted in fast wake.
    logic fastOk; // Sleep mode just left allows fast wake.
    logic fastRun; // CPU runs on the low clock until the crystal is ready.
    logic [31:0] prdata; // Read data.
    logic pready; // Access phase answer.
    logic pslverr; // Unmapped address.
    logic cpuRun; // CPU clocked.
    logic lsOn; // Low-speed clock running.
    logic wdtOn; // Watchdog clock running.
    logic hsOn; // High-speed oscillator enabled.
    logic wdtClr; // Watchdog clear pulse.
  } spmc_ctrl_t;

  spmc_ctrl_t s_r;
  spmc_ctrl_t s_nxt;
  logic [1:0] srcSel; // Source handed to the tick generator.
  logic [2:0] divShift; // Ratio handed to the tick generator.
  logic needHs; // Software selection asks for the high-speed clock.
  logic [1:0] normSrc; // Source for normal running.
  logic goDeep; // Halt would lead to deep sleep.
  logic setupPhase; // APB setup cycle.
  logic wrDone; // APB write completes at this edge.
  logic [31:0] rdVal; // Read data for the addressed register.
  logic mapped; // Address hits a register.
  logic [10:0] lsTarget; // Low-speed ready count for the fitted oscillator.
  logic [10:0] hsTarget; // High-speed ready count for the fitted oscillator.

  // Glitch-free divider and selector for the system clock.
  spmc_clk_gen u_clk_gen (
    .mclk(mclk),
    .reset(reset),
    .lsTick(lsTick),
    .hsTick(hsTick),
    .srcSel(srcSel),
    .divShift(divShift),
    .sysTick(sysTick)
  );

  // Decode of the clock selection and of the APB request.
  always_comb begin
    needHs = s_r.high_clock_select | (s_r.divSel >= spmc_pkg::DIV_FIRST_HS); // R7 R8
    divShift = spmc_pkg::div_shift(s_r.high_clock_select, s_r.divSel); // R7 R8
    // The low clock carries the CPU while a newly chosen high clock is still settling.
    normSrc = (needHs && s_r.hsRdy) ? spmc_pkg::SRC_HS : spmc_pkg::SRC_LS;
    // Any low-speed user forces light sleep instead of deep sleep.
    goDeep = !s_r.voltage_detector_enable && !s_r.lcdEn && !wdtEnable; // R1 R2
    lsTarget = lsIsCrystal ? spmc_pkg::CNT_XTAL : spmc_pkg::CNT_LS_RC; // R9 R14
    hsTarget = hsIsCrystal ? spmc_pkg::CNT_XTAL : spmc_pkg::CNT_HS_RC; // R10 R14
    setupPhase = psel && !penable;
    wrDone = psel && penable && s_r.pready && pwrite;
    mapped = 1'b1;
    rdVal = 32'h0000_0000;
    unique case (paddr)
      spmc_pkg::OFS_MODE: begin
        rdVal[spmc_pkg::MODE_DIV_HI:spmc_pkg::MODE_DIV_LO] = s_r.divSel;
        rdVal[spmc_pkg::MODE_FAST] = s_r.fastEn;
        rdVal[spmc_pkg::MODE_LSRDY] = s_r.lsRdy;
        rdVal[spmc_pkg::MODE_HSRDY] = s_r.hsRdy;
        rdVal[spmc_pkg::MODE_IDLE] = s_r.idleEn;
        rdVal[spmc_pkg::MODE_HIGH_CLOCK_SELECT] = s_r.high_clock_select;
      end
      spmc_pkg::OFS_IDLE: begin
        // Bits 6 to 3 are unimplemented and stay zero.
        rdVal[spmc_pkg::IDLE_KEEP] = s_r.keepClk; // R15
        rdVal[spmc_pkg::IDLE_FLAGS_HI:spmc_pkg::IDLE_FLAGS_LO] = s_r.rstFlags;
      end
      spmc_pkg::OFS_STATUS: begin
        rdVal[spmc_pkg::STAT_PDF] = s_r.power_down_flag;
        rdVal[spmc_pkg::STAT_TO] = s_r.wdtTo;
      end
      spmc_pkg::OFS_ENABLES: begin
        rdVal[spmc_pkg::EN_LVD] = s_r.voltage_detector_enable;
        rdVal[spmc_pkg::EN_LCD] = s_r.lcdEn;
      end
      default: begin
        // Unmapped offsets read zero and answer with an error.
        mapped = 1'b0;
      end
    endcase
  end

  // Next-state logic for registers, mode sequencing and oscillator readiness.
  always_comb begin
    s_nxt = s_r;
    s_nxt.wdtClr = 1'b0;

    // APB: the answer is prepared in the setup cycle so the access phase needs no wait state.
    if (setupPhase) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = rdVal;
      s_nxt.pslverr = !mapped;
    end else if (psel && penable && s_r.pready) begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end

    // Register writes; an unmapped write is dropped.
    if (wrDone) begin
      unique case (paddr)
        spmc_pkg::OFS_MODE: begin
          s_nxt.divSel = pwdata[spmc_pkg::MODE_DIV_HI:spmc_pkg::MODE_DIV_LO]; // R7
          s_nxt.fastEn = pwdata[spmc_pkg::MODE_FAST]; // R11
          s_nxt.idleEn = pwdata[spmc_pkg::MODE_IDLE];
          s_nxt.high_clock_select = pwdata[spmc_pkg::MODE_HIGH_CLOCK_SELECT]; // R8
        end
        spmc_pkg::OFS_IDLE: begin
          s_nxt.keepClk = pwdata[spmc_pkg::IDLE_KEEP]; // R15
          s_nxt.rstFlags = pwdata[spmc_pkg::IDLE_FLAGS_HI:spmc_pkg::IDLE_FLAGS_LO];
        end
        spmc_pkg::OFS_STATUS: begin
          // Writing one clears a flag; a hardware set in the same cycle overrides below.
          if (pwdata[spmc_pkg::STAT_PDF]) begin
            s_nxt.power_down_flag = 1'b0;
          end
          if (pwdata[spmc_pkg::STAT_TO]) begin
            s_nxt.wdtTo = 1'b0;
          end
        end
        spmc_pkg::OFS_ENABLES: begin
          s_nxt.voltage_detector_enable = pwdata[spmc_pkg::EN_LVD];
          s_nxt.lcdEn = pwdata[spmc_pkg::EN_LCD];
        end
        default: begin
          // Nothing is stored; the error answer was given in the setup cycle and ends with the access.
        end
      endcase
    end

    // A watchdog time-out sets its flag and wins over a register write clear in the same cycle; a halt in that cycle still clears it.
    if (wdtTimeout) begin
      s_nxt.wdtTo = 1'b1;
    end

    // Operating state machine.
    unique case (s_r.st)
      spmc_pkg::ST_RUN: begin
        s_nxt.cpuRun = 1'b1;
        s_nxt.lsOn = 1'b1;
        s_nxt.wdtOn = wdtEnable;
        // The crystal stays on during fast wake; otherwise it follows the selection.
        s_nxt.hsOn = needHs || s_r.fastRun; // R8 R13
        if (s_r.fastRun && s_r.hsRdy) begin
          s_nxt.fastRun = 1'b0; // R13
        end
        if (haltReq) begin
          // Every sleep or idle entry clears the watchdog and marks power-down.
          s_nxt.cpuRun = 1'b0;
          s_nxt.wdtClr = 1'b1;
          s_nxt.power_down_flag = 1'b1; // R16
          s_nxt.wdtTo = 1'b0; // R16
          s_nxt.fastRun = 1'b0;
          if (!s_r.idleEn && goDeep) begin
            // Everything stops; the watchdog gets one clear pulse and is left unclocked.
            s_nxt.st = spmc_pkg::ST_DEEP; // R1 R2
            s_nxt.lsOn = 1'b0; // R1
            s_nxt.wdtOn = 1'b0; // R1
            s_nxt.hsOn = 1'b0;
          end else if (!s_r.idleEn) begin
            // Some low-speed user keeps the low clock and watchdog clock going.
            s_nxt.st = spmc_pkg::ST_LIGHT; // R2 R3
            s_nxt.lsOn = 1'b1; // R3
            s_nxt.wdtOn = 1'b1; // R3
            s_nxt.hsOn = 1'b0;
          end else if (!s_r.keepClk) begin
            s_nxt.st = spmc_pkg::ST_IDLE_STOP; // R4
            s_nxt.lsOn = 1'b1; // R4
            s_nxt.wdtOn = wdtEnable && wdtSrcLow; // R5
            s_nxt.hsOn = 1'b0; // R4
          end else begin
            s_nxt.st = spmc_pkg::ST_IDLE_RUN; // R6
            s_nxt.lsOn = 1'b1;
            s_nxt.wdtOn = 1'b1; // R6
            s_nxt.hsOn = needHs; // R6
          end
        end
      end
      spmc_pkg::ST_DEEP, spmc_pkg::ST_LIGHT, spmc_pkg::ST_IDLE_STOP: begin
        if (wakeReq) begin
          // Fast wake needs a running low clock, so deep sleep never qualifies.
          s_nxt.st = spmc_pkg::ST_WAKE;
          s_nxt.fastOk = (s_r.st != spmc_pkg::ST_DEEP); // R12
          s_nxt.lsOn = 1'b1;
          s_nxt.wdtOn = wdtEnable;
          s_nxt.hsOn = needHs;
          s_nxt.wakeCnt = 2'h0;
        end
      end
      spmc_pkg::ST_IDLE_RUN: begin
        // The system oscillator never stopped, so the CPU resumes at once.
        if (wakeReq) begin
          s_nxt.st = spmc_pkg::ST_RUN;
          s_nxt.cpuRun = 1'b1;
        end
      end
      spmc_pkg::ST_WAKE: begin
        if (s_r.fastEn && hsIsCrystal && needHs && s_r.fastOk) begin
          // Resume on the low clock after a few of its cycles; the crystal takes over once ready.
          if (lsTick) begin
            s_nxt.wakeCnt = s_r.wakeCnt + 2'h1;
          end
          if (lsTick && (s_r.wakeCnt + 2'h1 == spmc_pkg::CNT_FAST)) begin
            s_nxt.st = spmc_pkg::ST_RUN; // R11 R13
            s_nxt.fastRun = 1'b1; // R13
            s_nxt.cpuRun = 1'b1;
          end
        end else if (needHs ? s_r.hsRdy : s_r.lsRdy) begin
          // Without fast wake the CPU waits for its own oscillator to settle.
          s_nxt.st = spmc_pkg::ST_RUN; // R14
          s_nxt.cpuRun = 1'b1;
        end
      end
    endcase

    // Low-speed readiness restarts whenever the low clock is stopped.
    if (!s_nxt.lsOn) begin
      s_nxt.lsCnt = 11'h000;
      s_nxt.lsRdy = 1'b0; // R9
    end else if (!s_r.lsRdy && lsTick) begin
      s_nxt.lsCnt = s_r.lsCnt + 11'h001;
      if (s_r.lsCnt + 11'h001 >= lsTarget) begin
        s_nxt.lsRdy = 1'b1; // R9
      end
    end

    // High-speed readiness likewise restarts whenever the oscillator is disabled.
    if (!s_nxt.hsOn) begin
      s_nxt.hsCnt = 11'h000;
      s_nxt.hsRdy = 1'b0; // R10
    end else if (!s_r.hsRdy && hsTick) begin
      s_nxt.hsCnt = s_r.hsCnt + 11'h001;
      if (s_r.hsCnt + 11'h001 >= hsTarget) begin
        s_nxt.hsRdy = 1'b1; // R10 R13
      end
    end
  end

  // Source given to the tick generator for the present state.
  always_comb begin
    srcSel = spmc_pkg::SRC_OFF;
    if (s_r.st == spmc_pkg::ST_RUN) begin
      srcSel = s_r.fastRun ? spmc_pkg::SRC_LS : normSrc; // R13
    end else if (s_r.st == spmc_pkg::ST_IDLE_RUN) begin
      // Peripherals keep the system clock in idle running.
      srcSel = normSrc; // R6
    end
  end

  // State register; power-on values follow the documented defaults.
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= spmc_pkg::ST_WAKE;
      s_r.divSel <= spmc_pkg::RST_DIV;
      s_r.fastEn <= spmc_pkg::RST_FAST;
      s_r.idleEn <= spmc_pkg::RST_IDLE;
      s_r.high_clock_select <= spmc_pkg::RST_HIGH_CLOCK_SELECT;
      s_r.keepClk <= spmc_pkg::RST_KEEP;
      s_r.rstFlags <= spmc_pkg::RST_FLAGS;
      s_r.lsOn <= 1'b1;
      s_r.hsOn <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign cpuRun = s_r.cpuRun;
  assign lsClkOn = s_r.lsOn;
  assign wdtClkOn = s_r.wdtOn;
  assign hsOscOn = s_r.hsOn;
  assign wdtClear = s_r.wdtClr;
  assign fastWakeActive = s_r.fastRun;
  assign powerState = s_r.st;

endmodule

// ---- spmc_sysclk_power_mode_ctrl_sva.sv ----
// Port checker for the system clock and power mode controller.
`timescale 1ns/1ns

module spmc_sysclk_power_mode_ctrl_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic haltReq,
  input wire logic wakeReq,
  input wire logic wdtEnable,
  input wire logic wdtSrcLow,
  input wire logic pready,
  input wire logic cpuRun,
  input wire logic lsClkOn,
  input wire logic wdtClkOn,
  input wire logic wdtClear,
  input wire logic fastWakeActive,
  input wire logic [5:0] powerState
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // High while one of the three stopped states is held.
  logic stopped;
  assign stopped = powerState inside {spmc_pkg::ST_DEEP, spmc_pkg::ST_LIGHT, spmc_pkg::ST_IDLE_STOP};

  // A halt request taken while running.
  sequence s_halt;
    powerState == spmc_pkg::ST_RUN && haltReq;
  endsequence
  // An APB setup cycle.
  sequence s_setup;
    psel && !penable;
  endsequence

  a_halt_enters_sleep: assert property (s_halt |=> !cpuRun && wdtClear &&
    powerState inside {spmc_pkg::ST_DEEP, spmc_pkg::ST_LIGHT, spmc_pkg::ST_IDLE_STOP, spmc_pkg::ST_IDLE_RUN})
    else $error("halt did not enter a sleep state");
  a_wdt_blocks_deep: assert property (s_halt ##0 wdtEnable |=> powerState != spmc_pkg::ST_DEEP)
    else $error("deep sleep entered with watchdog on");
  a_deep_clocks_off: assert property (powerState == spmc_pkg::ST_DEEP |-> !lsClkOn && !wdtClkOn && !cpuRun)
    else $error("clock left running in deep sleep");
  a_light_clocks_on: assert property (powerState == spmc_pkg::ST_LIGHT |-> lsClkOn && wdtClkOn)
    else $error("light sleep stopped low clocks");
  a_idle_wdt_src: assert property (powerState == spmc_pkg::ST_IDLE_STOP && wdtEnable |-> wdtClkOn == wdtSrcLow)
    else $error("watchdog clock wrong in idle stop");
  a_idle_run_wake: assert property (powerState == spmc_pkg::ST_IDLE_RUN && wakeReq |=>
    powerState == spmc_pkg::ST_RUN && cpuRun)
    else $error("idle running did not resume at once");
  a_stop_wake: assert property (stopped && wakeReq |=> powerState == spmc_pkg::ST_WAKE && !cpuRun)
    else $error("wake from stop did not start wake-up");
  a_sleep_holds: assert property (stopped && !wakeReq |=> $stable(powerState))
    else $error("sleep state left without wake");
  a_fast_runs_cpu: assert property (fastWakeActive |-> powerState == spmc_pkg::ST_RUN && cpuRun)
    else $error("fast wake active while CPU stopped");
  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("APB answer not single cycle");
endmodule

// ---- tb_sysclk_power_mode_ctrl.sv ----
// Self-checking testbench of the system clock and power mode controller.
`timescale 1ns/1ns

module tb_sysclk_power_mode_ctrl;
  // Bench-driven inputs, all given a value at time zero.
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, rerr, haltReq = 0, wakeReq = 0, lsTick = 0, hsTick = 0;
  logic wdtEnable = 0, wdtSrcLow = 1, wdtTimeout = 0;
  logic sysTick, cpuRun, lsClkOn, wdtClkOn, hsOscOn, wdtClear, fastWakeActive;
  logic [5:0] powerState;
  logic [2:0] tickCnt = 3'h0;
  int mismatches = 0, n_tests = 0;

  always #20 mclk = ~mclk;

  // Oscillator model: a low tick every eighth cycle, a high tick every second.
  always @(posedge mclk) begin
    tickCnt <= tickCnt + 3'h1;
    lsTick <= (tickCnt == 3'h7);
    hsTick <= tickCnt[0];
  end

  // Low oscillator is an RC type and high one a crystal, fixed by configuration.
  spmc_sysclk_power_mode_ctrl i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .haltReq(haltReq), .wakeReq(wakeReq), .lsTick(lsTick), .hsTick(hsTick), .lsIsCrystal(1'b0),
    .hsIsCrystal(1'b1), .wdtEnable(wdtEnable), .wdtSrcLow(wdtSrcLow), .wdtTimeout(wdtTimeout),
    .sysTick(sysTick), .cpuRun(cpuRun), .lsClkOn(lsClkOn), .wdtClkOn(wdtClkOn), .hsOscOn(hsOscOn),
    .wdtClear(wdtClear), .fastWakeActive(fastWakeActive), .powerState(powerState));

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one value; an unknown never matches.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulses halt or wake for one cycle, then lets the answer settle.
  task automatic pulse(input logic wake);
    @(posedge mclk);
    if (wake) wakeReq <= 1'b1;
    else haltReq <= 1'b1;
    wdtTimeout <= 1'b0;
    @(posedge mclk);
    wakeReq <= 1'b0;
    haltReq <= 1'b0;
    #1;
  endtask

  // Bounded wait for a state, since wake-up may take a full crystal count.
  task automatic wait_state(input logic [5:0] st);
    int n;
    n = 0;
    while (powerState !== st && n < 6000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("powerState", 32'(powerState), 32'(st));
    if (powerState !== st) stop_test();
  endtask

  // Reset values, reserved bits and an unmapped address.
  task automatic t_regs();
    apb(1'b0, spmc_pkg::OFS_MODE, 32'h0);
    check("mode", rdat, 32'h0000_000F);
    apb(1'b1, spmc_pkg::OFS_IDLE, 32'h0000_00FF);
    apb(1'b0, spmc_pkg::OFS_IDLE, 32'h0);
    check("idle reg", rdat, 32'h0000_0087);
    apb(1'b1, spmc_pkg::OFS_IDLE, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", 32'(rerr), 32'h1);
  endtask

  // Halts with one setting, checks the state, flags and ready bits, then wakes.
  task automatic t_sleep(input logic idle, input logic keep, input logic [1:0] en, input logic wdtEn,
                         input logic [5:0] st, input logic [1:0] rdy);
    wdtEnable <= wdtEn;
    apb(1'b1, spmc_pkg::OFS_MODE, {30'h0, idle, 1'b1});
    apb(1'b1, spmc_pkg::OFS_IDLE, {24'h0, keep, 7'h0});
    apb(1'b1, spmc_pkg::OFS_ENABLES, {30'h0, en});
    @(posedge mclk);
    wdtTimeout <= 1'b1;
    pulse(1'b0);
    check("sleep state", 32'(powerState), 32'(st));
    check("wdtClear", 32'(wdtClear), 32'h1);
    apb(1'b0, spmc_pkg::OFS_STATUS, 32'h0);
    check("status", rdat, 32'h0000_0001);
    apb(1'b0, spmc_pkg::OFS_MODE, 32'h0);
    check("ready bits", 32'(rdat[3:2]), 32'(rdy));
    pulse(1'b1);
    wait_state(spmc_pkg::ST_RUN);
    apb(1'b1, spmc_pkg::OFS_STATUS, 32'h0000_0003);
  endtask

  // Waits a bounded time for the fast wake indication to reach a level.
  task automatic wait_fast(input logic v);
    int n;
    n = 0;
    while (fastWakeActive !== v && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("fastWakeActive", 32'(fastWakeActive), 32'(v));
    if (fastWakeActive !== v) stop_test();
  endtask

  // Fast wake from idle stop runs on the low clock; from deep sleep it must not.
  task automatic t_fast();
    logic seen;
    wdtEnable <= 1'b1;
    apb(1'b1, spmc_pkg::OFS_IDLE, 32'h0);
    apb(1'b1, spmc_pkg::OFS_MODE, 32'h0000_0013);
    pulse(1'b0);
    pulse(1'b1);
    wait_fast(1'b1);
    check("cpuRun fast", 32'(cpuRun), 32'h1);
    apb(1'b0, spmc_pkg::OFS_MODE, 32'h0);
    check("hs not ready", 32'(rdat[2]), 32'h0);
    wait_fast(1'b0);
    apb(1'b0, spmc_pkg::OFS_MODE, 32'h0);
    check("hs ready", 32'(rdat[2]), 32'h1);
    wdtEnable <= 1'b0;
    apb(1'b1, spmc_pkg::OFS_MODE, 32'h0000_0011);
    pulse(1'b0);
    check("deep", 32'(powerState), 32'(spmc_pkg::ST_DEEP));
    pulse(1'b1);
    seen = 1'b0;
    for (int n = 0; n < 3000 && powerState !== spmc_pkg::ST_RUN; n++) begin
      @(posedge mclk);
      #1;
      seen = seen | fastWakeActive;
    end
    check("no fast from deep", 32'(seen), 32'h0);
    check("wake from deep", 32'(powerState), 32'(spmc_pkg::ST_RUN));
  endtask

  // Measures the system tick period for high select and every divider code.
  task automatic t_clock();
    int n;
    for (int c = 8; c >= 0; c--) begin
      apb(1'b1, spmc_pkg::OFS_MODE, (c == 8) ? 32'h1 : {24'h0, 3'(c), 5'h0});
      repeat (300) @(posedge mclk);
      #1;
      n = 0;
      while (sysTick !== 1'b1 && n < 400) begin
        @(posedge mclk);
        #1;
        n++;
      end
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (sysTick !== 1'b1 && n < 400);
      check("sysTick period", 32'(n), (c < 2) ? 32'h8 : 32'(2 << (8 - c)));
      if (n >= 400) stop_test();
    end
    check("hsOscOn", 32'(hsOscOn), 32'h0);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    wait_state(spmc_pkg::ST_RUN);
    t_regs();
    t_sleep(1'b0, 1'b0, 2'h0, 1'b0, spmc_pkg::ST_DEEP, 2'h0);
    t_sleep(1'b0, 1'b0, 2'h1, 1'b0, spmc_pkg::ST_LIGHT, 2'h2);
    t_sleep(1'b0, 1'b0, 2'h2, 1'b0, spmc_pkg::ST_LIGHT, 2'h2);
    t_sleep(1'b0, 1'b0, 2'h0, 1'b1, spmc_pkg::ST_LIGHT, 2'h2);
    t_sleep(1'b1, 1'b0, 2'h0, 1'b1, spmc_pkg::ST_IDLE_STOP, 2'h2);
    // A watchdog on the divided system clock must lose its clock in idle stop.
    wdtSrcLow <= 1'b0;
    t_sleep(1'b1, 1'b0, 2'h0, 1'b1, spmc_pkg::ST_IDLE_STOP, 2'h2);
    wdtSrcLow <= 1'b1;
    t_sleep(1'b1, 1'b1, 2'h0, 1'b1, spmc_pkg::ST_IDLE_RUN, 2'h3);
    t_fast();
    t_clock();
    stop_test();
  end
endmodule

bind spmc_sysclk_power_mode_ctrl spmc_sysclk_power_mode_ctrl_sva i_sva (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .haltReq(haltReq), .wakeReq(wakeReq), .wdtEnable(wdtEnable),
  .wdtSrcLow(wdtSrcLow), .pready(pready), .cpuRun(cpuRun), .lsClkOn(lsClkOn), .wdtClkOn(wdtClkOn),
  .wdtClear(wdtClear), .fastWakeActive(fastWakeActive), .powerState(powerState));
